// ---- logic/lak_consts.vh ----
`ifndef LAK_CONSTS_VH
`define LAK_CONSTS_VH
// ****************************************
// Register map (APB byte addresses)
// ****************************************
`define LAK_ADDR_CTRL 12'h000
`define LAK_ADDR_AUTO 12'h004
`define LAK_ADDR_LEDST 12'h008
`define LAK_ADDR_OUTST 12'h00c
`define LAK_ADDR_MISCST 12'h010
`define LAK_ADDR_SWACK 12'h014
// ****************************************
// Field positions, sizes and reset values
// ****************************************
`define LAK_CTRL_PERMIT 0
`define LAK_SWACK_LED 0
`define LAK_SWACK_OUT 1
`define LAK_SWACK_SCADA 2
`define LAK_NUM_LED 14
`define LAK_NUM_OUT 16
`define LAK_NUM_SCADA 8
`define LAK_NUM_TRIP 4
`define LAK_GROUP_LEDS 7
`define LAK_CTRL_RESET 32'h00000001
`define LAK_AUTO_RESET 32'h00000000
// ****************************************
// Timing
// ****************************************
`define LAK_CLK_MHZ 10
`define LAK_OFFDELAY_US 1000
`define LAK_OFFDELAY_CYC (`LAK_OFFDELAY_US * `LAK_CLK_MHZ)
`endif

// ---- logic/lak_latch_acknowledge.v ----
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "lak_consts.vh"
module lak_latch_acknowledge #(
  parameter OFF_DELAY = `LAK_OFFDELAY_CYC
) (
  input wire core_clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire [13:0] ledSet, // LED setting signals (pins)
  input wire [15:0] outSet, // Output setting signals
  input wire [7:0] scadaSet, // SCADA setting signals
  input wire [3:0] tripSet, // Trip command setting signals
  input wire [13:0] ledClearSource, // Per-LED clear sources
  input wire [15:0] outClearSource, // Per-output clear sources
  input wire [3:0] tripLatchClearSource, // Per-switchgear trip clear
  input wire allLedClearSource, // Collective LED clear
  input wire allOutputClearSource, // Collective output clear
  input wire allScadaClearSource, // Collective SCADA clear
  input wire scadaLinkAck, // Acknowledge request from SCADA link
  input wire protAlarm, // Any protection alarm or general alarm
  output reg [13:0] ledLatched, // LED latch states
  output reg [15:0] outLatched, // Output relay latch states
  output reg [7:0] scadaLatched, // SCADA latch states
  output reg [3:0] tripLatched // Trip command latch states
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  // Every set and clear pin is asynchronous to core_clk, so all of them pass two stages
  localparam SW = 14 + 16 + 8 + 4 + 14 + 16 + 4 + 5;
  // Level inputs that set latches, most significant group first
  wire [41:0] rawSet = {ledSet, outSet, scadaSet, tripSet};
  // Clear sources, alarm in the lowest bit
  wire [38:0] rawClr = {ledClearSource, outClearSource, tripLatchClearSource,
    allLedClearSource, allOutputClearSource, allScadaClearSource, scadaLinkAck,
    protAlarm};
  wire [SW-1:0] rawIn = {rawSet, rawClr};
  reg [SW-1:0] sync1_reg;
  reg [SW-1:0] sync2_reg;
  reg [SW-1:0] prev_reg;
  always @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= {SW{1'b0}};
      sync2_reg <= {SW{1'b0}};
      // Zero matches the idle level of the pins, so no false edge follows reset
      prev_reg <= {SW{1'b0}};
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  // Sources act on their rising edge, so a held source clears only once
  wire [SW-1:0] rise = sync2_reg & ~prev_reg;
  wire [13:0] sLed = sync2_reg[SW-1 -: 14];
  wire [15:0] sOut = sync2_reg[SW-15 -: 16];
  wire [7:0] sScada = sync2_reg[SW-31 -: 8];
  wire [3:0] sTrip = sync2_reg[SW-39 -: 4];
  wire [13:0] eLedClr = rise[SW-43 -: 14];
  wire [15:0] eOutClr = rise[SW-57 -: 16];
  wire [3:0] eTripClr = rise[SW-73 -: 4];
  wire eAllLed = rise[4];
  wire eAllOut = rise[3];
  wire eAllScada = rise[2];
  wire eLinkAck = rise[1];
  wire eAlarm = rise[0];
  // ****************************************
  // Functions
  // ****************************************
  // Set input beats any clear, so a clear never hides a live indication
  function [15:0] latchNext;
    input [15:0] cur;
    input [15:0] setIn;
    input [15:0] req;
    begin
      latchNext = setIn | (cur & ~(req & ~setIn));
    end
  endfunction
  // Register write decode, used by every writable register
  function regHit;
    input wr;
    input [11:0] addr;
    input [11:0] target;
    begin
      regHit = wr & (addr == target);
    end
  endfunction
  // ****************************************
  // Registers
  // ****************************************
  reg permit_reg;
  reg [13:0] autoAck_reg;
  reg [2:0] swAck_reg;
  wire wrEn = psel & penable & pwrite;
  // Zero wait states: every register answers in its access cycle
  assign pready = 1'b1;
  // Unmapped reads return zero as well as the error flag
  assign pslverr = psel & penable & (paddr > `LAK_ADDR_SWACK);
  reg [31:0] rdMux;
  always @* begin
    case (paddr)
      `LAK_ADDR_CTRL: rdMux = {31'h0, permit_reg};
      `LAK_ADDR_AUTO: rdMux = {18'h0, autoAck_reg};
      `LAK_ADDR_LEDST: rdMux = {18'h0, ledLatched};
      `LAK_ADDR_OUTST: rdMux = {16'h0, outLatched};
      `LAK_ADDR_MISCST: rdMux = {20'h0, tripLatched, scadaLatched};
      default: rdMux = 32'h0;
    endcase
  end
  // Read data is registered in the setup cycle and stands through access
  reg [31:0] prdata_reg;
  assign prdata = prdata_reg;
  always @(posedge core_clk) begin
    if (rst) begin
      permit_reg <= 1'b1;
      autoAck_reg <= 14'h0;
      swAck_reg <= 3'h0;
      prdata_reg <= 32'h0;
    end else begin
      prdata_reg <= (psel & ~pwrite) ? rdMux : 32'h0;
      // Software acknowledges are one-cycle pulses and read back as zero
      swAck_reg <= 3'h0;
      if (regHit(wrEn, paddr, `LAK_ADDR_CTRL))
        permit_reg <= pwdata[`LAK_CTRL_PERMIT];
      if (regHit(wrEn, paddr, `LAK_ADDR_AUTO))
        autoAck_reg <= pwdata[13:0];
      if (regHit(wrEn, paddr, `LAK_ADDR_SWACK))
        swAck_reg <= pwdata[2:0];
    end
  end
  // ****************************************
  // Acknowledge requests
  // ****************************************
  // permit gates external and software requests, but not the alarm auto-acknowledge
  wire [13:0] extLedReq = permit_reg ? (eLedClr | {14{eAllLed}}) : 14'h0;
  wire linkAck = permit_reg & (eLinkAck | swAck_reg[`LAK_SWACK_SCADA]);
  wire ledAllReq = permit_reg & swAck_reg[`LAK_SWACK_LED];
  wire [13:0] alarmReq = eAlarm ? autoAck_reg : 14'h0;
  wire [13:0] ledReq = extLedReq | {14{ledAllReq}} | alarmReq;
  wire outAllReq = eAllOut | swAck_reg[`LAK_SWACK_OUT];
  wire [15:0] outReq = permit_reg ? (eOutClr | {16{outAllReq}}) : 16'h0;
  wire [7:0] scadaReq = (permit_reg & eAllScada) | linkAck ? 8'hff : 8'h0;
  wire [3:0] tripReq = permit_reg ? eTripClr : 4'h0;
  // ****************************************
  // Latches
  // ****************************************
  // Pending output acknowledges wait for the off-delay before release
  reg [15:0] outPend_reg;
  reg [15:0] offDone;
  reg [31:0] offCnt_reg [0:15];
  integer i;
  integer j;
  // Counters saturate at the delay, so a long idle output never wraps
  always @* begin
    for (j = 0; j < 16; j = j + 1) begin
      offDone[j] = (offCnt_reg[j] >= OFF_DELAY);
    end
  end
  // LED, SCADA and trip latches share one next-state rule
  wire [15:0] ledNext = latchNext({2'h0, ledLatched}, {2'h0, sLed}, {2'h0, ledReq});
  wire [15:0] scadaNext = latchNext({8'h0, scadaLatched}, {8'h0, sScada}, {8'h0, scadaReq});
  wire [15:0] tripNext = latchNext({12'h0, tripLatched}, {12'h0, sTrip}, {12'h0, tripReq});
  // Pending output acknowledges are released only once the off-delay has run
  wire [15:0] outRelease = outPend_reg & offDone & ~sOut;
  always @(posedge core_clk) begin
    if (rst) begin
      ledLatched <= 14'h0;
      outLatched <= 16'h0;
      scadaLatched <= 8'h0;
      tripLatched <= 4'h0;
      outPend_reg <= 16'h0;
      for (i = 0; i < 16; i = i + 1)
        offCnt_reg[i] <= 32'h0;
    end else begin
      // single LED clear; source inactive; set wins
      ledLatched <= ledNext[13:0];
      scadaLatched <= scadaNext[7:0];
      tripLatched <= tripNext[3:0];
      for (i = 0; i < 16; i = i + 1) begin
        if (sOut[i])
          offCnt_reg[i] <= 32'h0;
        else if (!offDone[i])
          offCnt_reg[i] <= offCnt_reg[i] + 32'h1;
      end
      outPend_reg <= (outPend_reg | (outReq & outLatched)) & ~sOut & ~outRelease;
      outLatched <= sOut | (outLatched & ~outRelease);
    end
  end
endmodule

// ---- testbench/lak_ack_properties.sv ----
`timescale 1ns/10ps
module lak_ack_chk (
  input wire core_clk, rst, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready, pslverr,
  input wire [13:0] ledSet, ledLatched,
  input wire [15:0] outSet, outLatched,
  input wire [3:0] tripSet, tripLatched
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  sequence ledHeld; ledSet[0] [*3]; endsequence
  a_ready_const: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr > 12'h014 |-> pslverr && (pwrite ||
    prdata == 32'h0)) else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && paddr <= 12'h014 |-> !pslverr)
    else $error("mapped access flagged");
  a_led_sets: assert property (ledSet[0] [*4] |=> ledLatched[0]) else $error("LED not set");
  a_led_hold:
    assert property (ledHeld ##0 ledLatched[0] |=> ledLatched[0]) else $error("LED cleared");
  a_out_hold:
    assert property (outSet[3] [*3] |=> outLatched[3]) else $error("output cleared");
  a_out_release:
    assert property ($fell(outLatched[0]) |-> !$past(outSet[0], 3) && !$past(outSet[0], 8))
    else $error("output released early");
  a_trip_hold:
    assert property (tripSet[1] [*5] |-> tripLatched[1]) else $error("trip cleared");
endmodule
bind lak_latch_acknowledge lak_ack_chk chk (.*);

// ---- testbench/lak_src_model.sv ----
`timescale 1ns/10ps
module lak_src_model (
  input wire core_clk, // Clock
  input wire [38:0] fire, // One-cycle request per source
  output reg [38:0] srcLevel = 39'h0 // Held source levels
);
  reg [2:0] holdCnt = 3'h0;
  // Hold long enough to pass the input synchronisers
  always @(posedge core_clk) begin
    if (fire != 39'h0) begin
      srcLevel <= fire;
      holdCnt <= 3'h5;
    end else if (holdCnt != 3'h0) holdCnt <= holdCnt - 3'h1;
    else srcLevel <= 39'h0;
  end
endmodule

// ---- testbench/latch_acknowledge_logic_test.sv ----
`timescale 1ns/10ps
module latch_acknowledge_logic_test;
  reg core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [41:0] setV = 42'h0;
  reg [38:0] fire = 39'h0;
  wire [38:0] src;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [13:0] ledL;
  wire [15:0] outL;
  wire [7:0] scL;
  wire [3:0] trL;
  wire [41:0] lat = {ledL, outL, scL, trL};
  int errTotal = 0, nCompared = 0, i;
  reg [47:0] rows [0:9] = '{{6'd25, 42'h3ff_efff_ffff}, {6'd38, 42'h1ff_ffff_ffff},
    {6'd9, 42'h3ff_ffff_efff}, {6'd24, 42'h3ff_f7ff_ffff}, {6'd7, 42'h3ff_ffff_fffb},
    {6'd4, 42'h000_0fff_ffff}, {6'd3, 42'h3ff_f000_0fff}, {6'd2, 42'h3ff_ffff_f00f},
    {6'd0, 42'h3ff_ffff_ffff}, {6'd1, 42'h3ff_ffff_f00f}};
  always #50 core_clk = ~core_clk;
  lak_src_model src0 (.core_clk(core_clk), .fire(fire), .srcLevel(src));
  lak_latch_acknowledge #(.OFF_DELAY(8)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ledSet(setV[41:28]), .outSet(setV[27:12]),
    .scadaSet(setV[11:4]), .tripSet(setV[3:0]), .ledClearSource(src[38:25]),
    .outClearSource(src[24:9]), .tripLatchClearSource(src[8:5]), .allLedClearSource(src[4]),
    .allOutputClearSource(src[3]), .allScadaClearSource(src[2]), .scadaLinkAck(src[1]),
    .protAlarm(src[0]), .ledLatched(ledL), .outLatched(outL), .scadaLatched(scL),
    .tripLatched(trL));
  task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask
  task automatic testDone;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input [41:0] e, input [41:0] s);
    nCompared++;
    if (s !== e) begin
      errTotal++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    int k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++k < 20);
    rd = prdata; er = pslverr;
    if (k == 20) begin errTotal++; testDone; end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input [38:0] f);
    setV <= '1; tick(5); setV <= '0; tick(3);
    fire <= f; tick(1); fire <= '0; tick(20);
  endtask
  initial begin
    tick(6); rst <= 1'b0; tick(1);
    chk("latch reset", 0, lat);
    apb(0, 12'h000, 0); chk("ctrl reset", 1, rd);
    apb(0, 12'h004, 0); chk("auto reset", 0, rd);
    for (i = 0; i < 10; i++) begin
      pulse(39'h1 << rows[i][47:42]);
      chk("row", rows[i][41:0], lat);
    end
    $display("table done");
    apb(1, 12'h004, 32'h2041); pulse(39'h1);
    chk("auto", {14'h1fbe, 28'hfff_ffff}, lat);
    apb(1, 12'h000, 0); apb(1, 12'h014, 7);
    fire <= 39'h7f_ffff_fffe; tick(1); fire <= '0; tick(20);
    chk("permit off", {14'h1fbe, 28'hfff_ffff}, lat);
    apb(1, 12'h000, 1); apb(1, 12'h014, 1); tick(3);
    apb(0, 12'h008, 0); chk("led status", 0, rd);
    apb(1, 12'h014, 6); tick(3);
    apb(0, 12'h00c, 0); chk("out status", 0, rd);
    apb(0, 12'h010, 0); chk("misc status", 32'h0f00, rd);
    apb(0, 12'h018, 0); chk("slverr", 1, er);
    chk("unmapped", 0, rd);
    setV <= '1; tick(5); setV <= 42'h000_1000_0000; fire <= 39'h0200_0200;
    tick(1); fire <= '0; tick(5);
    chk("off delay", 1, outL[0]);
    tick(20); chk("set wins", 42'h3ff_ffff_efff, lat);
    $display("hand tests done");
    testDone;
  end
endmodule
